// >>> hdl/cgw_defs.svh
// Register offsets, field positions, reset values and codes of the clock gear and warm-up block.
`ifndef CGW_DEFS_SVH
`define CGW_DEFS_SVH

`define CGW_OFS_SYSCLK 8'h00
`define CGW_OFS_OSCWUP 8'h04
`define CGW_OFS_IRQSTAT 8'h08
`define CGW_OFS_IRQMASK 8'h0C

`define CGW_POS_PERIPH_SOURCE_SELECT 12
`define CGW_POS_PERIPH_PRESCALE_RATIO 8
`define CGW_POS_GEAR 0
`define CGW_POS_WARMUP_TIME_UPPER 20
`define CGW_POS_WARMUP_TIME_LOW_BITS 14
`define CGW_POS_ZERO2 12
`define CGW_POS_LOW_SPEED_OSC_ENABLE 9
`define CGW_POS_XEN 8
`define CGW_POS_FIXED4 4
`define CGW_POS_WARMUP_SOURCE_SELECT 3
`define CGW_POS_PLL_RUN 2
`define CGW_POS_WARMUP_BUSY_FLAG 1
`define CGW_POS_WARMUP_START 0

`define CGW_RST_WARMUP_TIME_UPPER 12'h800
`define CGW_RST_FIXED4 4'h3
`define CGW_MASKED_BITS 4

`define CGW_GEAR_DIV1 3'h0
`define CGW_GEAR_DIV2 3'h4
`define CGW_GEAR_DIV4 3'h5
`define CGW_GEAR_DIV8 3'h6
`define CGW_PERIPH_PRESCALE_RATIO_MAX 3'h5

`define CGW_EV_DONE 0
`define CGW_EV_START 1

`define CGW_RESP_OKAY 2'h0
`define CGW_RESP_SLVERR 2'h2

`endif

// >>> hdl/cgw_pkg.sv
// Types shared by the clock gear and warm-up block.
package cgw_pkg;
   typedef struct packed {
      logic [2:0] cnt_sel;
      logic [31:0] cnt;
      logic out;
   } cgw_div_state_t;

   typedef struct packed {
      logic periph_source_select;
      logic [2:0] periph_prescale_ratio;
      logic [2:0] gear;
   } cgw_sysclk_t;

   typedef struct packed {
      logic [11:0] warmup_time_upper;
      logic [1:0] warmup_time_low_bits;
      logic [1:0] zero2;
      logic low_speed_osc_enable;
      logic high_speed_osc_enable;
      logic [3:0] fixed4;
      logic warmup_source_select;
      logic pll_run;
   } cgw_osc_t;

   typedef struct packed {
      cgw_sysclk_t sys;
      cgw_osc_t osc;
      logic warmup_busy_flag;
      logic [17:0] wcnt;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic [2:0] hs_sync;
      logic [2:0] ls_sync;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cgw_state_t;
endpackage : cgw_pkg

// >>> hdl/cgw_div_if.sv
// Carrier between the control logic and one tick divider.
interface cgw_div_if;
   logic [2:0] shift;
   logic in_tick;
   logic out_tick;
   modport ctl (output shift, output in_tick, input out_tick);
   modport div (input shift, input in_tick, output out_tick);
endinterface : cgw_div_if

// >>> hdl/cgw_divider.sv
// Power-of-two tick divider: one output tick per 2**shift input ticks.
module cgw_divider
   import cgw_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET,
   // Divider carrier.
   cgw_div_if.div dv
);
   cgw_div_state_t st_reg;
   cgw_div_state_t st_next;
   logic [31:0] lim;

   always_comb begin
      st_next = st_reg;
      lim = (32'h1 << dv.shift) - 32'h1;
      st_next.cnt_sel = dv.shift;
      st_next.out = 1'b0;
      // A changed ratio restarts the count so no short pulse leaks out.
      if (dv.shift != st_reg.cnt_sel) begin
         st_next.cnt = 32'h0;
      end else if (dv.in_tick) begin
         if (st_reg.cnt >= lim) begin
            st_next.cnt = 32'h0;
            st_next.out = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dv.out_tick = st_reg.out;
endmodule : cgw_divider

// >>> hdl/cgw_top.sv
// Clock gear, prescaler, oscillator enable and warm-up timer control with AXI4-Lite registers.
// Functional notes
// - Bit 12 selects geared or undivided source.
// - Prescaler codes 000-101 divide by 1..32.
// - Gear codes 000,100,101,110 divide 1,2,4,8.
// - Bits 31-20 set warm-up count time.
// - Counters 16/18 bits, low 4 masked.
// - Bits 15-14 give low-speed count's low bits.
// - Bit 3 picks high- or low-speed warm-up source.
// - Bit 2 runs the PLL, reset stopped.
// - Bit 1 reads 1 while warming up.
// - Writing 1 to bit 0 starts warm-up.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`include "cgw_defs.svh"

module cgw_top
   import cgw_pkg::*;
#(
   // Warm-up counter widths and the low bits that the compare leaves out.
   parameter int HS_CNT_W = 16,
   parameter int LS_CNT_W = 18,
   parameter int MASK_W = `CGW_MASKED_BITS
)
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET,
   // Oscillator inputs used as warm-up count clocks.
   input wire logic HIGH_SPEED_OSC_PIN,
   input wire logic LOW_SPEED_OSC_PIN,
   // Oscillator and PLL controls.
   output logic HIGH_SPEED_OSC_EN,
   output logic LOW_SPEED_OSC_EN,
   output logic PLL_RUN,
   // Clock ticks.
   output logic GEAR_TICK,
   output logic PERIPH_TICK,
   // Interrupt.
   output logic IRQ,
   // AXI4-Lite write address.
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // AXI4-Lite write data.
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response.
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read address.
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // AXI4-Lite read data.
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   cgw_state_t st_reg;
   cgw_state_t st_next;

   cgw_div_if gear_dv ();
   cgw_div_if periph_dv ();

   logic [31:0] sys_word;
   logic [31:0] osc_word;
   logic [31:0] wr_word;
   logic [31:0] wmask;
   logic wr_fire;
   logic rd_fire;
   logic osc_edge;
   logic [17:0] wcnt_inc;
   logic [17:0] target;
   logic [HS_CNT_W-1:0] hs_target;
   logic [LS_CNT_W-1:0] ls_target;
   logic [1:0] events;
   logic [1:0] rd_clear;

   // Byte lanes of the write data that the master marked as valid.
   assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                   {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};

   // Gear divider runs on every CLK cycle.
   always_comb begin
      case (st_reg.sys.gear)
         `CGW_GEAR_DIV1: gear_dv.shift = 3'h0;
         `CGW_GEAR_DIV2: gear_dv.shift = 3'h1;
         `CGW_GEAR_DIV4: gear_dv.shift = 3'h2;
         `CGW_GEAR_DIV8: gear_dv.shift = 3'h3;
         default: gear_dv.shift = 3'h0;
      endcase
   end
   assign gear_dv.in_tick = 1'b1;

   // Reserved prescale codes fall back to divide-by-1 of the selected source.
   assign periph_dv.shift = (st_reg.sys.periph_prescale_ratio > `CGW_PERIPH_PRESCALE_RATIO_MAX) ?
                            3'h0 : st_reg.sys.periph_prescale_ratio;
   assign periph_dv.in_tick = st_reg.sys.periph_source_select ?
                              1'b1 : gear_dv.out_tick;

   cgw_divider u_gear_div (
      .CLK(CLK),
      .RESET(RESET),
      .dv(gear_dv.div)
   );

   cgw_divider u_periph_div (
      .CLK(CLK),
      .RESET(RESET),
      .dv(periph_dv.div)
   );

   // Read images; unused positions stay zero.
   always_comb begin
      sys_word = 32'h0;
      sys_word[`CGW_POS_PERIPH_SOURCE_SELECT] = st_reg.sys.periph_source_select;
      sys_word[`CGW_POS_PERIPH_PRESCALE_RATIO +: 3] = st_reg.sys.periph_prescale_ratio;
      sys_word[`CGW_POS_GEAR +: 3] = st_reg.sys.gear;
      osc_word = 32'h0;
      osc_word[`CGW_POS_WARMUP_TIME_UPPER +: 12] = st_reg.osc.warmup_time_upper;
      osc_word[`CGW_POS_WARMUP_TIME_LOW_BITS +: 2] = st_reg.osc.warmup_time_low_bits;
      osc_word[`CGW_POS_ZERO2 +: 2] = st_reg.osc.zero2;
      osc_word[`CGW_POS_LOW_SPEED_OSC_ENABLE] = st_reg.osc.low_speed_osc_enable;
      osc_word[`CGW_POS_XEN] = st_reg.osc.high_speed_osc_enable;
      osc_word[`CGW_POS_FIXED4 +: 4] = st_reg.osc.fixed4;
      osc_word[`CGW_POS_WARMUP_SOURCE_SELECT] = st_reg.osc.warmup_source_select;
      osc_word[`CGW_POS_PLL_RUN] = st_reg.osc.pll_run;
      osc_word[`CGW_POS_WARMUP_BUSY_FLAG] = st_reg.warmup_busy_flag;
   end

   // Handshakes complete one cycle after the ready flops rise.
   assign wr_fire = st_reg.awready & st_reg.wready;
   assign rd_fire = st_reg.arready;

   // The selected oscillator is counted on its synchronised rising edge.
   always_comb begin
      if (st_reg.osc.warmup_source_select) begin
         osc_edge = st_reg.ls_sync[1] & ~st_reg.ls_sync[2];
      end else begin
         osc_edge = st_reg.hs_sync[1] & ~st_reg.hs_sync[2];
      end
   end

   // Compare value: the lowest MASK_W bits are always zero, which trades count
   // resolution for a short time field.
   always_comb begin
      hs_target = '0;
      ls_target = '0;
      hs_target[HS_CNT_W-1 -: 12] = st_reg.osc.warmup_time_upper;
      ls_target[LS_CNT_W-1 -: 12] = st_reg.osc.warmup_time_upper;
      ls_target[MASK_W +: 2] = st_reg.osc.warmup_time_low_bits;
      if (st_reg.osc.warmup_source_select) begin
         target = 18'(ls_target);
      end else begin
         target = 18'(hs_target);
      end
   end
   assign wcnt_inc = st_reg.wcnt + 18'h1;

   always_comb begin
      st_next = st_reg;
      events = 2'h0;
      rd_clear = 2'h0;
      wr_word = 32'h0;

      // Two-stage synchronisers, plus a third stage for edge detection.
      st_next.hs_sync = {st_reg.hs_sync[1:0], HIGH_SPEED_OSC_PIN};
      st_next.ls_sync = {st_reg.ls_sync[1:0], LOW_SPEED_OSC_PIN};

      // Warm-up counting.
      if (st_reg.warmup_busy_flag && osc_edge) begin
         st_next.wcnt = wcnt_inc;
         if (wcnt_inc >= target) begin
            st_next.warmup_busy_flag = 1'b0;
            events[`CGW_EV_DONE] = 1'b1;
         end
      end

      // Write channel.
      st_next.awready = 1'b0;
      st_next.wready = 1'b0;
      if (S_AXI_AWVALID && S_AXI_WVALID && !st_reg.awready && !st_reg.bvalid) begin
         st_next.awready = 1'b1;
         st_next.wready = 1'b1;
      end
      if (st_reg.bvalid && S_AXI_BREADY) begin
         st_next.bvalid = 1'b0;
      end
      if (wr_fire) begin
         st_next.bvalid = 1'b1;
         st_next.bresp = `CGW_RESP_OKAY;
         case (S_AXI_AWADDR)
            `CGW_OFS_SYSCLK: begin
               wr_word = (sys_word & ~wmask) | (S_AXI_WDATA & wmask);
               st_next.sys.periph_source_select = wr_word[`CGW_POS_PERIPH_SOURCE_SELECT];
               st_next.sys.periph_prescale_ratio = wr_word[`CGW_POS_PERIPH_PRESCALE_RATIO +: 3];
               st_next.sys.gear = wr_word[`CGW_POS_GEAR +: 3];
            end
            `CGW_OFS_OSCWUP: begin
               wr_word = (osc_word & ~wmask) | (S_AXI_WDATA & wmask);
               st_next.osc.warmup_time_upper = wr_word[`CGW_POS_WARMUP_TIME_UPPER +: 12];
               st_next.osc.warmup_time_low_bits = wr_word[`CGW_POS_WARMUP_TIME_LOW_BITS +: 2];
               st_next.osc.zero2 = wr_word[`CGW_POS_ZERO2 +: 2];
               st_next.osc.low_speed_osc_enable = wr_word[`CGW_POS_LOW_SPEED_OSC_ENABLE];
               st_next.osc.high_speed_osc_enable = wr_word[`CGW_POS_XEN];
               st_next.osc.fixed4 = wr_word[`CGW_POS_FIXED4 +: 4];
               st_next.osc.warmup_source_select = wr_word[`CGW_POS_WARMUP_SOURCE_SELECT];
               st_next.osc.pll_run = wr_word[`CGW_POS_PLL_RUN];
               // A start while busy restarts the count from zero.
               if (S_AXI_WSTRB[0] && S_AXI_WDATA[`CGW_POS_WARMUP_START]) begin
                  st_next.warmup_busy_flag = 1'b1;
                  st_next.wcnt = 18'h0;
                  events[`CGW_EV_START] = 1'b1;
                  events[`CGW_EV_DONE] = 1'b0;
               end
            end
            `CGW_OFS_IRQSTAT: begin
               st_next.bresp = `CGW_RESP_OKAY;
            end
            `CGW_OFS_IRQMASK: begin
               if (S_AXI_WSTRB[0]) begin
                  st_next.mask = S_AXI_WDATA[1:0];
               end
            end
            default: begin
               st_next.bresp = `CGW_RESP_SLVERR;
            end
         endcase
      end

      // Read channel.
      st_next.arready = 1'b0;
      if (S_AXI_ARVALID && !st_reg.arready && !st_reg.rvalid) begin
         st_next.arready = 1'b1;
      end
      if (st_reg.rvalid && S_AXI_RREADY) begin
         st_next.rvalid = 1'b0;
      end
      if (rd_fire) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = `CGW_RESP_OKAY;
         case (S_AXI_ARADDR)
            `CGW_OFS_SYSCLK: st_next.rdata = sys_word;
            `CGW_OFS_OSCWUP: st_next.rdata = osc_word;
            `CGW_OFS_IRQSTAT: begin
               st_next.rdata = {30'h0, st_reg.stat};
               rd_clear = st_reg.stat;
            end
            `CGW_OFS_IRQMASK: st_next.rdata = {30'h0, st_reg.mask};
            default: begin
               st_next.rdata = 32'h0;
               st_next.rresp = `CGW_RESP_SLVERR;
            end
         endcase
      end

      // A new event in the clearing cycle survives, since it is set after the clear.
      st_next.stat = (st_reg.stat & ~rd_clear) | events;
      st_next.irq = |(st_next.stat & st_next.mask);
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_reg <= '0;
         st_reg.osc.warmup_time_upper <= `CGW_RST_WARMUP_TIME_UPPER;
         st_reg.osc.fixed4 <= `CGW_RST_FIXED4;
         st_reg.osc.low_speed_osc_enable <= 1'b1;
         st_reg.osc.high_speed_osc_enable <= 1'b1;
         st_reg.osc.pll_run <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from state flops.
   assign HIGH_SPEED_OSC_EN = st_reg.osc.high_speed_osc_enable;
   assign LOW_SPEED_OSC_EN = st_reg.osc.low_speed_osc_enable;
   assign PLL_RUN = st_reg.osc.pll_run;
   assign GEAR_TICK = gear_dv.out_tick;
   assign PERIPH_TICK = periph_dv.out_tick;
   assign IRQ = st_reg.irq;
   assign S_AXI_AWREADY = st_reg.awready;
   assign S_AXI_WREADY = st_reg.wready;
   assign S_AXI_BVALID = st_reg.bvalid;
   assign S_AXI_BRESP = st_reg.bresp;
   assign S_AXI_ARREADY = st_reg.arready;
   assign S_AXI_RVALID = st_reg.rvalid;
   assign S_AXI_RDATA = st_reg.rdata;
   assign S_AXI_RRESP = st_reg.rresp;
endmodule : cgw_top

// >>> verification/cgw_top_props.sv
// Port assertions for the clock gear and warm-up block.
module cgw_top_props (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET,
   // Oscillator, PLL and gear outputs.
   input wire logic HIGH_SPEED_OSC_EN,
   input wire logic LOW_SPEED_OSC_EN,
   input wire logic PLL_RUN,
   input wire logic GEAR_TICK,
   // Bus handshakes.
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   // A request counts only while the slave is idle, so a held valid is not seen twice.
   sequence wr_seen;
      S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
   endsequence
   sequence wr_answer;
      S_AXI_AWREADY && S_AXI_WREADY ##1 S_AXI_BVALID && !S_AXI_AWREADY;
   endsequence
   sequence rd_seen;
      S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
   endsequence
   sequence rd_answer;
      S_AXI_ARREADY ##1 S_AXI_RVALID && !S_AXI_ARREADY;
   endsequence
   wr_latency_a: assert property (wr_seen |=> wr_answer)
      else $error("Write answer late.");
   rd_latency_a: assert property (rd_seen |=> rd_answer)
      else $error("Read answer late.");
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("Write response dropped.");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("Read data dropped.");
   b_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("Write response kept.");
   pll_reset_a: assert property ($fell(RESET) |-> !PLL_RUN)
      else $error("PLL runs after reset.");
   osc_reset_a: assert property ($fell(RESET) |-> HIGH_SPEED_OSC_EN && LOW_SPEED_OSC_EN)
      else $error("Oscillator stopped after reset.");
   gear_start_a: assert property ($fell(RESET) |-> ##[1:3] GEAR_TICK)
      else $error("No gear tick after reset.");
endmodule : cgw_top_props

// >>> verification/cgw_top_tb_top.sv
// Self-checking bench for the clock gear and warm-up block.
module cgw_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, hs_pin, hs_en, ls_en, pll, gtick, ptick, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [2:0] lsc;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp;
   logic [33:0] rq[$], bq[$];
   int n_fail, comparisons, cyc, cg, cp;
   int gd[8] = '{1, 1, 1, 1, 2, 4, 8, 1};

   cgw_top cgw_top_inst (
      .CLK(clk), .RESET(rst), .HIGH_SPEED_OSC_PIN(hs_pin), .LOW_SPEED_OSC_PIN(lsc[2]),
      .HIGH_SPEED_OSC_EN(hs_en), .LOW_SPEED_OSC_EN(ls_en), .PLL_RUN(pll),
      .GEAR_TICK(gtick), .PERIPH_TICK(ptick), .IRQ(irq),
      .S_AXI_AWADDR(addr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(addr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
   );

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : cmp

   // Handshakes are judged at the rising edge; a late ready makes the slave hold its answer.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      logic av, dv, done, late;
      int k;
      if (w) bq.push_back({r, 32'h0});
      else rq.push_back({r, d});
      av = 1'b1;
      dv = w;
      done = 1'b0;
      late = 1'($urandom());
      k = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w && !late;
      rready <= !w && !late;
      while (!done && k < 50) begin
         @(posedge clk);
         k++;
         av = av && !(w ? awready : arready);
         dv = dv && !wready;
         done = w ? (bvalid && bready) : (rvalid && rready);
         awvalid <= w && av;
         wvalid <= dv;
         arvalid <= !w && av;
         bready <= w && !done && (!late || k > 2);
         rready <= !w && !done && (!late || k > 2);
      end
      if (!done) cmp(34'h0, 34'h1);
   endtask : xfer

   // A divider restarts just after a ratio write, so two cycles pass first; then a
   // window of 512 cycles holds a whole number of every tick period.
   task automatic meas;
      cg = 0;
      cp = 0;
      repeat (2) @(posedge clk);
      repeat (512) begin
         @(negedge clk);
         cg += gtick;
         cp += ptick;
      end
   endtask : meas

   task automatic warm(input logic s, input logic [11:0] u, input logic [1:0] l, input int e);
      logic [31:0] d;
      d = {u, 4'h0, l, 6'h03, 4'h3, s, 3'b001};
      xfer(1, 8'h04, d, 2'h0);
      @(negedge clk);
      cmp({33'h0, irq}, 34'h0);
      xfer(0, 8'h04, d ^ 32'h3, 2'h0);
      repeat (e - e / 8) @(posedge clk);
      xfer(0, 8'h04, d ^ 32'h3, 2'h0);
      repeat (e / 8 + 40) @(posedge clk);
      xfer(0, 8'h04, d ^ 32'h1, 2'h0);
      xfer(1, 8'h04, d ^ 32'h1, 2'h0);
      xfer(0, 8'h04, d ^ 32'h1, 2'h0);
      @(negedge clk);
      cmp({33'h0, irq}, 34'h1);
      xfer(0, 8'h08, 32'h3, 2'h0);
      repeat (3) @(negedge clk);
      cmp({33'h0, irq}, 34'h0);
   endtask : warm

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      hs_pin <= !hs_pin;
      lsc <= lsc + 3'h1;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         report_and_stop();
      end
   end

   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) cmp({rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready === 1'b1) cmp({bresp, 32'h0}, bq.pop_front());
   end

   initial begin
      rst = 1'b1;
      {hs_pin, lsc, awvalid, wvalid, bready, arvalid, rready, addr, wdata} = '0;
      {n_fail, comparisons, cyc} = '0;
      void'($urandom(50570));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp({31'h0, pll, hs_en, ls_en}, 34'h3);
      xfer(0, 8'h00, 32'h0, 2'h0);
      xfer(0, 8'h04, 32'h80000330, 2'h0);
      xfer(0, 8'h10, 32'h0, 2'h2);
      xfer(1, 8'h10, 32'hFFFFFFFF, 2'h2);
      xfer(1, 8'h08, 32'hFFFFFFFF, 2'h0);
      xfer(0, 8'h08, 32'h0, 2'h0);
      for (int i = 0; i < 4; i++) begin
         v = ($urandom() & 32'hFFF0C30C) | 32'h30;
         xfer(1, 8'h04, v, 2'h0);
         xfer(0, 8'h04, v, 2'h0);
         @(negedge clk);
         cmp({31'h0, pll, hs_en, ls_en}, {31'h0, v[2], v[8], v[9]});
         v = $urandom();
         xfer(1, 8'h00, v, 2'h0);
         xfer(0, 8'h00, v & 32'h00001707, 2'h0);
      end
      for (int g = 0; g < 8; g++) begin
         for (int p = 0; p < 8; p++) begin
            v = {19'h0, 1'(g ^ p), 1'b0, 3'(p), 5'h0, 3'(g)};
            xfer(1, 8'h00, v, 2'h0);
            meas();
            cmp(34'(cg), 34'(512 / gd[g]));
            cmp(34'(cp), 34'(512 / ((v[12] ? 1 : gd[g]) << (p > 5 ? 0 : p))));
         end
      end
      xfer(1, 8'h0C, 32'h1, 2'h0);
      xfer(0, 8'h0C, 32'h1, 2'h0);
      warm(1'b0, 12'h008, 2'h0, 256);
      warm(1'b1, 12'h001, 2'h1, 640);
      report_and_stop();
   end
endmodule : cgw_top_tb_top

bind cgw_top cgw_top_props cgw_top_props_inst (
   .CLK, .RESET, .HIGH_SPEED_OSC_EN, .LOW_SPEED_OSC_EN, .PLL_RUN, .GEAR_TICK,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
   .S_AXI_RVALID, .S_AXI_RREADY
);
